//--- adc_readout_pkg.sv
// Package: constants, states and functional notes for the converter readout block
package adc_readout_pkg;

  localparam int unsigned RESULT_W     = 18;
  localparam int unsigned CLK_MHZ      = 200;
  // Longest conversion time in ns (1.52 us)
  localparam int unsigned T_CONV_NS    = 1520;
  // Longest time rounds down
  localparam int unsigned CONV_CYCLES  = (T_CONV_NS * CLK_MHZ) / 1000;
  localparam int unsigned CNT_W        = 9;
  // One successive-approximation step per bit, paced by an internal bit clock
  localparam int unsigned BIT_CYCLES   = CONV_CYCLES / (RESULT_W + 1);
  localparam logic [CNT_W-1:0] BIT_DIV = CNT_W'(BIT_CYCLES - 1);
  localparam logic [4:0] LAST_BIT      = 5'(RESULT_W - 1);
  localparam int unsigned INIT_CYCLES  = 3;
  localparam logic [RESULT_W-1:0] RESULT_RST = 18'h00000;

  typedef enum logic [1:0] {ST_ACQUIRE, ST_CONVERT, ST_DONE} conv_state_t;

endpackage : adc_readout_pkg

//--- conv_if.sv
// Interface: handshake between conversion sequencer and approximation engine
`timescale 1ns/1ps
`default_nettype none
interface conv_if;
  logic                  start;
  logic                  done;
  logic [17:0]           code;
  modport seq (output start, input done, input code);
  modport eng (input start, output done, output code);
endinterface // conv_if
`default_nettype wire

//--- sar_engine.sv
// Successive-approximation engine with its own internal bit clock divider
`timescale 1ns/1ps
`default_nettype none
module sar_engine
  import adc_readout_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                rstn_i,
  // Held analog sample compared against the trial code
  input  wire logic [RESULT_W-1:0] sample_i,
  // Sequencer side
  conv_if.eng                      cv
);
  logic [CNT_W-1:0]    div_q;
  logic                bit_en;
  logic [4:0]          bit_q;
  logic                run_q;
  logic [RESULT_W-1:0] trial_q;
  logic                done_q;

  // ----------------------------------------
  // Internal conversion clock
  // ----------------------------------------
  // No external clock: the bit step is a divided enable
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      div_q <= '0;
    else if (!run_q || bit_en)
      div_q <= '0;
    else
      div_q <= div_q + CNT_W'(1);
  end
  assign bit_en = run_q && (div_q == BIT_DIV);

  // ----------------------------------------
  // Bit decisions, MSB first
  // ----------------------------------------
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      run_q   <= 1'b0;
      bit_q   <= '0;
      trial_q <= RESULT_RST;
      done_q  <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (cv.start)
      begin
        run_q   <= 1'b1;
        bit_q   <= LAST_BIT;
        trial_q <= {1'b1, {(RESULT_W-1){1'b0}}};
      end
      else if (bit_en)
      begin
        // Keep the trial bit when the sample is not below the trial code
        if (sample_i < trial_q)
          trial_q[bit_q] <= 1'b0;
        if (bit_q == 5'd0)
        begin
          run_q  <= 1'b0;
          done_q <= 1'b1;
        end
        else
        begin
          trial_q[bit_q - 5'd1] <= 1'b1;
          bit_q <= bit_q - 5'd1;
        end
      end
    end
  end

  assign cv.done = done_q;
  assign cv.code = trial_q;
endmodule // sar_engine
`default_nettype wire

//--- sar_adc_parallel_readout.sv
// Top: conversion sequencing and folded parallel result readout
`timescale 1ns/1ps
`default_nettype none
module sar_adc_parallel_readout
  import adc_readout_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                rstn_i,
  // Digitised analog input, tracked while acquiring
  input  wire logic [RESULT_W-1:0] analog_code_i,
  // Host control
  input  wire logic                conversion_trigger_n_i,
  input  wire logic                unit_select_n_i,
  input  wire logic                read_strobe_n_i,
  input  wire logic                bus_width_select_i,
  input  wire logic                fold_select_i,
  // Status
  output logic                     busy_o,
  output logic                     sampling_o,
  output logic                     init_done_o,
  // Read-back of the bus pins, not used by the logic
  input  wire logic [RESULT_W-1:0] result_bus_i,
  // Driven data and its per-line enable
  output logic [RESULT_W-1:0]      result_bus_o,
  output logic [RESULT_W-1:0]      result_bus_oe_o
);
  import adc_readout_pkg::*;

  conv_if cv ();

  conv_state_t         state_q;
  logic                trig_q;
  logic                sel_q;
  logic                busy_q;
  logic                trig_fall;
  logic                sel_fall;
  logic                busy_fall;
  logic                track_q;
  logic [RESULT_W-1:0] hold_q;
  logic [RESULT_W-1:0] result_q;
  logic [RESULT_W-1:0] bus_q;
  logic [1:0]          init_cnt_q;
  logic                bus_en;
  logic                start_sampling;
  logic [RESULT_W-1:0] next_result;

  // ----------------------------------------
  // Folding of the 18-bit result onto the bus lines
  // ----------------------------------------
  // Lines that carry no result bits read as one in every folded view
  function automatic logic [RESULT_W-1:0] fold_map(input logic [RESULT_W-1:0] r,
                                                   input logic wid,
                                                   input logic fold);
    logic [RESULT_W-1:0] m;
    m = {RESULT_W{1'b1}};
    case ({fold, wid})
      2'b00: m = r;
      2'b01: m[3:2] = r[1:0];
      2'b11: m[11:10] = r[1:0];
      2'b10: m[17:10] = r[9:2];
      default: m = r;
    endcase
    return m;
  endfunction

  // Trim loading is over once the power-on conversions have all finished
  function automatic logic init_complete(input logic [1:0] cnt);
    return cnt == 2'(INIT_CYCLES);
  endfunction

  // ----------------------------------------
  // Edge detection of host inputs
  // ----------------------------------------
  // Primed to the idle levels so that release of reset shows no false edge
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      trig_q <= 1'b1;
    else
      trig_q <= conversion_trigger_n_i;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      sel_q <= 1'b1;
    else
      sel_q <= unit_select_n_i;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      busy_q <= 1'b0;
    else
      busy_q <= busy_o;
  end

  assign trig_fall = trig_q && !conversion_trigger_n_i;
  assign sel_fall  = sel_q && !unit_select_n_i;
  assign busy_fall = busy_q && !busy_o;

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  // A trigger while deselected or mid-conversion is ignored
  // The done state leaves one idle cycle before the next trigger is taken
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      state_q <= ST_ACQUIRE;
    else
    begin
      case (state_q)
        ST_ACQUIRE:
          if (trig_fall && !unit_select_n_i)
            state_q <= ST_CONVERT;
        ST_CONVERT:
          if (cv.done)
            state_q <= ST_DONE;
        ST_DONE:
          state_q <= ST_ACQUIRE;
        default:
          state_q <= ST_ACQUIRE;
      endcase
    end
  end
  assign cv.start = (state_q == ST_ACQUIRE) && trig_fall && !unit_select_n_i;
  assign busy_o   = (state_q == ST_CONVERT);

  // ----------------------------------------
  // Sample and hold
  // ----------------------------------------
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      track_q <= 1'b0;
    else if (cv.start)
      track_q <= 1'b0;
    else if (start_sampling)
      track_q <= 1'b1;
  end

  // Acquisition length is the host's to keep; nothing here measures it
  assign start_sampling = (busy_fall && !unit_select_n_i) || (sel_fall && !busy_o);

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      hold_q <= RESULT_RST;
    else if (cv.start)
      hold_q <= analog_code_i;
  end
  assign sampling_o = track_q;

  // ----------------------------------------
  // Approximation engine
  // ----------------------------------------
  sar_engine u_engine (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .sample_i  (hold_q),
    .cv        (cv)
  );

  // ----------------------------------------
  // Power-on initialisation count
  // ----------------------------------------
  // Trim load occupies the first conversions; results before that read as zero
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      init_cnt_q <= '0;
    else if (cv.done && !init_complete(init_cnt_q))
      init_cnt_q <= init_cnt_q + 2'd1;
  end
  assign init_done_o = init_complete(init_cnt_q);

  // ----------------------------------------
  // Result capture
  // ----------------------------------------
  // Conversions that load trim data leave a zero result behind
  always_comb
  begin
    next_result = result_q;
    if (cv.done)
    begin
      if (init_complete(init_cnt_q))
        next_result = cv.code;
      else
        next_result = RESULT_RST;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      result_q <= RESULT_RST;
    else if (cv.done)
      result_q <= next_result;
  end

  // ----------------------------------------
  // Result bus
  // ----------------------------------------
  // Registered data: MSB valid on the same clock edge that busy falls, well inside 40 ns
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      bus_q <= {RESULT_W{1'b1}};
    else
      bus_q <= fold_map(next_result, bus_width_select_i, fold_select_i);
  end

  // Enable is combinational so the lines release as soon as the strobe rises

  assign bus_en          = !unit_select_n_i && !read_strobe_n_i;
  assign result_bus_o    = bus_q;
  assign result_bus_oe_o = {RESULT_W{bus_en}};

endmodule // sar_adc_parallel_readout
`default_nettype wire

//--- readout_assertions.sv
// Checker: trigger, conversion-time and bus-mapping properties of the readout block
`timescale 1ns/1ps
`default_nettype none
module readout_checker
  import adc_readout_pkg::*;
(
  // Clock, reset and host control
  input wire logic                clk_sys_i,
  input wire logic                rstn_i,
  input wire logic                conversion_trigger_n_i,
  input wire logic                unit_select_n_i,
  input wire logic                read_strobe_n_i,
  input wire logic                bus_width_select_i,
  input wire logic                fold_select_i,
  // Device outputs
  input wire logic                busy_o,
  input wire logic [RESULT_W-1:0] result_bus_o,
  input wire logic [RESULT_W-1:0] result_bus_oe_o
);
  // ----
  // Properties
  // ----
  logic       trig_q;
  logic [1:0] sel;
  logic       fall;
  assign sel  = {bus_width_select_i, fold_select_i};
  assign fall = trig_q && !conversion_trigger_n_i && !busy_o;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  // Primed high so a trigger already low at release is taken as an edge
  always_ff @(posedge clk_sys_i or negedge rstn_i)
    if (!rstn_i) trig_q <= 1'b1;
    else trig_q <= conversion_trigger_n_i;
  sequence s_hold;
    busy_o [*8];
  endsequence
  a_trig_busy: assert property (fall && !unit_select_n_i |=> s_hold)
    else $error("busy did not follow an accepted trigger");
  a_refused_trig: assert property (fall && unit_select_n_i |=> !busy_o)
    else $error("deselected trigger started a conversion");
  a_conv_bound: assert property ($rose(busy_o) |-> ##[1:304] !busy_o)
    else $error("conversion too long");
  a_bus_enable: assert property (result_bus_oe_o == {RESULT_W{!unit_select_n_i && !read_strobe_n_i}})
    else $error("bus enable wrong");
  a_width_ones: assert property (sel == 2'b10 && $stable(sel)
    |-> result_bus_o[17:4] == 14'h3FFF && result_bus_o[1:0] == 2'h3)
    else $error("width-only lines wrong");
  a_both_ones: assert property (sel == 2'b11 && $stable(sel)
    |-> result_bus_o[17:12] == 6'h3F && result_bus_o[9:0] == 10'h3FF)
    else $error("both-select lines wrong");
  a_fold_ones: assert property (sel == 2'b01 && $stable(sel) |-> result_bus_o[9:0] == 10'h3FF)
    else $error("fold-only lines wrong");
  a_result_hold: assert property (busy_o && $past(busy_o) && $stable(sel)
    && $past(sel) == $past(sel, 2) |-> $stable(result_bus_o))
    else $error("result moved during conversion");
endmodule // readout_checker
bind sar_adc_parallel_readout readout_checker chk (.clk_sys_i, .rstn_i, .conversion_trigger_n_i,
  .unit_select_n_i, .read_strobe_n_i, .bus_width_select_i, .fold_select_i, .busy_o,
  .result_bus_o, .result_bus_oe_o);
`default_nettype wire

//--- host_model.sv
// Host model: issues conversion triggers of legal width
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock and request
  input wire logic clk_sys_i,
  input wire logic go_i,
  // Trigger to the device
  output logic     trig_n_o
);
  // ----
  // Trigger pulse
  // ----
  initial trig_n_o = 1'b1;
  // 50 ns low; callers space requests far beyond the 20 ns high time
  always @(posedge go_i)
  begin
    @(negedge clk_sys_i);
    trig_n_o = 1'b0;
    repeat (10) @(negedge clk_sys_i);
    trig_n_o = 1'b1;
  end
endmodule // host_model
`default_nettype wire

//--- testbench.sv
// Testbench: conversions and folded reads compared with a bench model
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import adc_readout_pkg::*;
  // ----
  // Stimulus, model and checks
  // ----
  logic                clk_sys_i, rstn_i, go, cs_n, rd_n, wid, fold, trig_n;
  logic                busy, samp, init_done;
  logic [RESULT_W-1:0] code, bus, oe, want;
  logic [31:0]         rng;
  logic [RESULT_W-1:0] exp_q[$];
  int                  n_errors, num_checks, k, i, m;
  sar_adc_parallel_readout DUT (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .analog_code_i(code),
    .conversion_trigger_n_i(trig_n), .unit_select_n_i(cs_n), .read_strobe_n_i(rd_n),
    .bus_width_select_i(wid), .fold_select_i(fold), .busy_o(busy), .sampling_o(samp),
    .init_done_o(init_done), .result_bus_i(18'h00000), .result_bus_o(bus),
    .result_bus_oe_o(oe));
  host_model host (.clk_sys_i(clk_sys_i), .go_i(go), .trig_n_o(trig_n));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [17:0] fold_of(input logic [17:0] d, input int sel);
    case (sel)
      1: return {d[9:2], 10'h3FF};
      2: return {14'h3FFF, d[1:0], 2'h3};
      3: return {6'h3F, d[1:0], 10'h3FF};
      default: return d;
    endcase
  endfunction
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic pulse();
    go = 1'b1;
    @(negedge clk_sys_i);
    go = 1'b0;
  endtask
  // Bounded wait, so a stuck busy ends in a mismatch rather than a hang
  task automatic wait_busy(input logic b);
    for (k = 0; k < 400 && busy !== b; k++) @(negedge clk_sys_i);
  endtask
  task automatic give_verdict();
    if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  initial
  begin
    #100000;
    n_errors++;
    give_verdict();
  end
  initial
  begin
    {rstn_i, go, cs_n, rd_n, wid, fold} = 6'b000100;
    code = 18'h00000;
    rng = 66;
    repeat (3) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    cs_n = 1'b1;
    pulse();
    repeat (20) @(negedge clk_sys_i);
    check(18'(busy), 18'h0);
    cs_n = 1'b0;
    repeat (80) @(negedge clk_sys_i);
    check(18'(samp), 18'h1);
    for (i = 0; i < 6; i++)
    begin
      rng = xs(rng);
      code = rng[17:0];
      exp_q.push_back(i < 3 ? 18'h00000 : code);
      pulse();
      wait_busy(1'b1);
      check(18'(busy), 18'h1);
      check(18'(samp), 18'h0);
      wait_busy(1'b0);
      check(18'(busy), 18'h0);
      want = exp_q.pop_front();
      repeat (8) @(negedge clk_sys_i);
      check(18'(samp), 18'h1);
      check(18'(init_done), 18'(i >= 2));
      for (m = 0; m < 4; m++)
      begin
        {wid, fold} = 2'(m);
        repeat (2) @(negedge clk_sys_i);
        rd_n = 1'b0;
        repeat (12) @(negedge clk_sys_i);
        check(bus, fold_of(want, m));
        check(oe, 18'h3FFFF);
        rd_n = 1'b1;
        repeat (12) @(negedge clk_sys_i);
      end
      {wid, fold} = 2'b00;
      check(oe, 18'h00000);
      repeat (100) @(negedge clk_sys_i);
    end
    // Auto read: strobe held low across a whole conversion
    rd_n = 1'b0;
    rng = xs(rng);
    code = rng[17:0];
    pulse();
    wait_busy(1'b1);
    wait_busy(1'b0);
    repeat (8) @(negedge clk_sys_i);
    check(bus, code);
    check(oe, 18'h3FFFF);
    rd_n = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
